// *** logic/ufps_flash_service.sv ***
// Flash self-programming sequencer with APB register file
//
// Implementation choices: the address map and register access over APB.
`timescale 1ns/1ps
module ufps_flash_service import ufps_pkg::*; (
  input  wire logic            clk,
  input  wire logic            sys_rst,
  input  wire logic            psel,
  input  wire logic            penable,
  input  wire logic            pwrite,
  input  wire logic [APB_AW-1:0] paddr,
  input  wire logic [31:0]     pwdata,
  output logic [31:0]          prdata,
  output logic                 pready,
  output logic                 pslverr,
  output ufps_flash_req_t      flashReq,
  output logic                 flashReqValid,
  input  wire logic            flashAck,
  input  wire logic [7:0]      flashRdata,
  output ufps_ram_req_t        ramReq,
  output logic                 ramReqValid,
  input  wire logic [7:0]      ramRdata,
  input  wire logic            serialExit,
  output logic                 serialMode,
  output logic                 coreHold,
  output logic                 deviceReset
);
  // Register index from a byte address
  function automatic logic [7:0] regIdx(input logic [APB_AW-1:0] a);
    return a[9:2];
  endfunction

  ufps_state_t     stateReg;
  ufps_fop_t       curOp;
  logic            blockOp;
  logic [15:0]     curAddr;
  logic [7:0]      curX;
  logic [7:0]      remain;
  logic [7:0]      addrHiReg, addrLoReg, wrDataReg, rdDataReg;
  logic [7:0]      countReg, timingReg, accReg, xPtrReg;
  logic            keyErrReg, cmdErrReg, serialModeReg;
  logic            coreHoldReg, devRstReg, preadyReg, pslverrReg;
  logic [31:0]     prdataReg;
  ufps_flash_req_t flashReqReg;
  logic            flashValidReg;
  ufps_ram_req_t   ramReqReg;
  logic            ramValidReg;
  logic            keyLive;
  logic            apbWr, callWr, callOk, massDone;
  logic [7:0]      wIdx, ep;
  logic            goFlash, goBlkRd, goBlkWr, badCmd, doExit, doSerial;
  ufps_fop_t       goOp;
  logic [31:0]     rdMux;
  logic            hit;

  // Bus strobes
  assign wIdx   = regIdx(paddr);
  assign ep     = pwdata[7:0];
  assign apbWr  = psel && penable && preadyReg && pwrite && hit; // Refused addresses write nothing
  assign callWr = apbWr && (wIdx == IDX_CALL) && (stateReg == S_IDLE) && !serialModeReg;
  assign callOk = callWr && keyLive;
  assign massDone = (stateReg == S_STEP) && (curOp == FOP_MASS) && (remain == 8'h01);

  ufps_key_timer #(
    .WINDOW (KEY_WINDOW)
  ) u_key (
    .clk     (clk),
    .sys_rst (sys_rst),
    .keyLoad (apbWr && (wIdx == IDX_KEY) && (ep == KEY_VALUE)),
    .keyKill (callWr || (apbWr && (wIdx == IDX_KEY))),
    .keyLive (keyLive)
  );

  // Entry point decode
  always_comb begin
    goFlash  = 1'b0;
    goBlkRd  = 1'b0;
    goBlkWr  = 1'b0;
    badCmd   = 1'b0;
    doExit   = 1'b0;
    doSerial = 1'b0;
    goOp     = FOP_READ;
    case (ep)
      EP_PAGE_ERASE: begin
        goFlash = 1'b1;
        goOp    = FOP_PAGE;
      end
      EP_MASS_ERASE: begin
        goFlash = (accReg == MASS_CONFIRM);
        badCmd  = (accReg != MASS_CONFIRM);
        goOp    = FOP_MASS;
      end
      EP_READ_BYTE:  goFlash = 1'b1;
      EP_WRITE_BYTE: begin
        goFlash = 1'b1;
        goOp    = FOP_WRITE;
      end
      EP_BLOCK_READ: goBlkRd = (countReg != BYTE_RST);
      EP_BLOCK_WRITE: begin
        goBlkWr = (countReg != BYTE_RST) && (countReg <= BLKW_MAX);
        badCmd  = (countReg > BLKW_MAX);
        goOp    = FOP_WRITE;
      end
      EP_EXIT:   doExit = 1'b1;
      EP_SERIAL: doSerial = 1'b1;
      default:   badCmd = 1'b1;
    endcase
  end

  // Sequencer and request ports
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      stateReg      <= S_IDLE;
      curOp         <= FOP_READ;
      blockOp       <= 1'b0;
      curAddr       <= '0;
      curX          <= BYTE_RST;
      remain        <= BYTE_RST;
      rdDataReg     <= BYTE_RST;
      flashReqReg   <= '0;
      flashValidReg <= 1'b0;
      ramReqReg     <= '0;
      ramValidReg   <= 1'b0;
      coreHoldReg   <= 1'b0;
    end else begin
      flashValidReg <= 1'b0;
      ramValidReg   <= 1'b0;
      unique case (stateReg)
        S_IDLE: begin
          if (callOk && doSerial) begin
            coreHoldReg <= 1'b1;
          end
          if (callOk && (goFlash || goBlkRd || goBlkWr)) begin
            curOp       <= goBlkRd ? FOP_READ : goOp;
            blockOp     <= goBlkRd || goBlkWr;
            curAddr     <= {addrHiReg, addrLoReg};
            curX        <= xPtrReg;
            remain      <= (goBlkRd || goBlkWr) ? countReg : 8'h01;
            coreHoldReg <= 1'b1;
            flashReqReg <= '{op: goBlkRd ? FOP_READ : goOp, addr: {addrHiReg, addrLoReg},
                             wdata: wrDataReg, timing: timingReg};
            if (goBlkWr) begin
              ramReqReg   <= '{we: 1'b0, addr: xPtrReg, wdata: BYTE_RST};
              ramValidReg <= 1'b1;
              stateReg    <= S_RAMGET;
            end else begin
              flashValidReg <= 1'b1;
              stateReg      <= S_WAIT;
            end
          end
        end
        S_WAIT: begin
          if (flashAck) begin
            if (curOp == FOP_READ && !blockOp) begin
              rdDataReg <= flashRdata;
            end
            if (curOp == FOP_READ && blockOp) begin
              ramReqReg   <= '{we: 1'b1, addr: curX, wdata: flashRdata};
              ramValidReg <= 1'b1;
            end
            stateReg <= S_STEP;
          end
        end
        S_STEP: begin
          remain <= remain - 8'h01;
          if (remain == 8'h01) begin
            coreHoldReg <= (curOp == FOP_MASS);
            stateReg    <= S_IDLE;
          end else begin
            curAddr          <= curAddr + 16'h0001;
            curX             <= curX + 8'h01;
            flashReqReg.addr <= curAddr + 16'h0001;
            if (curOp == FOP_READ) begin
              flashValidReg <= 1'b1;
              stateReg      <= S_WAIT;
            end else begin
              ramReqReg   <= '{we: 1'b0, addr: curX + 8'h01, wdata: BYTE_RST};
              ramValidReg <= 1'b1;
              stateReg    <= S_RAMGET;
            end
          end
        end
        S_RAMGET: stateReg <= S_RAMLAT;
        S_RAMLAT: begin
          flashReqReg.wdata <= ramRdata;
          flashValidReg     <= 1'b1;
          stateReg          <= S_WAIT;
        end
        default: stateReg <= S_IDLE;
      endcase
    end
  end

  // Mode and device reset requests
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      serialModeReg <= 1'b0;
      devRstReg     <= 1'b0;
    end else begin
      if (massDone || (callOk && doSerial)) begin
        serialModeReg <= 1'b1;
      end
      devRstReg <= (callOk && doExit) || (serialModeReg && serialExit);
    end
  end

  // Sticky error flags; a new error beats a clear
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      keyErrReg <= 1'b0;
      cmdErrReg <= 1'b0;
    end else begin
      if (callWr && !keyLive) begin
        keyErrReg <= 1'b1;
      end else if (apbWr && (wIdx == IDX_STATUS) && pwdata[ST_KERR_BIT]) begin
        keyErrReg <= 1'b0;
      end
      if (callOk && badCmd) begin
        cmdErrReg <= 1'b1;
      end else if (apbWr && (wIdx == IDX_STATUS) && pwdata[ST_CERR_BIT]) begin
        cmdErrReg <= 1'b0;
      end
    end
  end

  // Parameter registers written by software
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      addrHiReg <= BYTE_RST;
      addrLoReg <= BYTE_RST;
      wrDataReg <= BYTE_RST;
      countReg  <= BYTE_RST;
      timingReg <= BYTE_RST;
      accReg    <= BYTE_RST;
      xPtrReg   <= BYTE_RST;
    end else if (apbWr) begin
      case (wIdx)
        IDX_ADDR_HI: addrHiReg <= ep;
        IDX_ADDR_LO: addrLoReg <= ep;
        IDX_WR_DATA: wrDataReg <= ep;
        IDX_COUNT:   countReg  <= ep;
        IDX_TIMING:  timingReg <= ep;
        IDX_ACC:     accReg    <= ep;
        IDX_XPTR:    xPtrReg   <= ep;
        default: ;
      endcase
    end
  end

  // Read data and address decode
  always_comb begin
    rdMux = 32'h0000_0000;
    hit   = 1'b1;
    case (wIdx)
      IDX_ADDR_HI: rdMux[7:0] = addrHiReg;
      IDX_ADDR_LO: rdMux[7:0] = addrLoReg;
      IDX_WR_DATA: rdMux[7:0] = wrDataReg;
      IDX_RD_DATA: rdMux[7:0] = rdDataReg;
      IDX_COUNT:   rdMux[7:0] = countReg;
      IDX_TIMING:  rdMux[7:0] = timingReg;
      IDX_ACC:     rdMux[7:0] = accReg;
      IDX_XPTR:    rdMux[7:0] = xPtrReg;
      IDX_KEY, IDX_CALL: rdMux = 32'h0000_0000;
      IDX_STATUS: begin
        rdMux[ST_BUSY_BIT] = (stateReg != S_IDLE);
        rdMux[ST_SER_BIT]  = serialModeReg;
        rdMux[ST_KERR_BIT] = keyErrReg;
        rdMux[ST_CERR_BIT] = cmdErrReg;
        rdMux[ST_KEY_BIT]  = keyLive;
      end
      default: hit = 1'b0;
    endcase
    if (paddr[1:0] != 2'h0 || paddr[APB_AW-1:10] != '0) begin
      hit = 1'b0;
    end
  end

  // APB answer: one wait-free access cycle after setup
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      preadyReg  <= 1'b0;
      pslverrReg <= 1'b0;
      prdataReg  <= 32'h0000_0000;
    end else begin
      preadyReg  <= psel && !penable;
      pslverrReg <= psel && !penable && !hit;
      prdataReg  <= (psel && !penable && !pwrite && hit) ? rdMux : 32'h0000_0000;
    end
  end

  assign prdata        = prdataReg;
  assign pready        = preadyReg;
  assign pslverr       = pslverrReg;
  assign flashReq      = flashReqReg;
  assign flashReqValid = flashValidReg;
  assign ramReq        = ramReqReg;
  assign ramReqValid   = ramValidReg;
  assign serialMode    = serialModeReg;
  assign coreHold      = coreHoldReg;
  assign deviceReset   = devRstReg;

  property p_dispatch;
    @(posedge clk) disable iff (sys_rst)
    callOk && ep == EP_READ_BYTE |=> flashReqValid && flashReq.op == FOP_READ;
  endproperty
  a_dispatch: assert property (p_dispatch)
    else $error("read byte entry not dispatched");

  property p_page;
    @(posedge clk) disable iff (sys_rst)
    callOk && ep == EP_PAGE_ERASE |=> flashReqValid && flashReq.op == FOP_PAGE
      && flashReq.addr == {$past(addrHiReg), $past(addrLoReg)};
  endproperty
  a_page: assert property (p_page)
    else $error("page erase request wrong");

  property p_mass_guard;
    @(posedge clk) disable iff (sys_rst)
    callOk && ep == EP_MASS_ERASE && accReg != MASS_CONFIRM |=> !flashReqValid [*2];
  endproperty
  a_mass_guard: assert property (p_mass_guard)
    else $error("mass erase without confirmation");

  property p_mass_serial;
    @(posedge clk) disable iff (sys_rst)
    massDone |=> serialModeReg && coreHoldReg && stateReg == S_IDLE;
  endproperty
  a_mass_serial: assert property (p_mass_serial)
    else $error("no serial mode after mass erase");

  property p_rd_byte;
    @(posedge clk) disable iff (sys_rst)
    stateReg == S_WAIT && flashAck && curOp == FOP_READ && !blockOp
      |=> rdDataReg == $past(flashRdata);
  endproperty
  a_rd_byte: assert property (p_rd_byte)
    else $error("read data not captured");

  property p_blk_rd;
    @(posedge clk) disable iff (sys_rst)
    stateReg == S_WAIT && flashAck && blockOp && curOp == FOP_READ
      |=> ramReqValid && ramReq.we && ramReq.addr == $past(curX);
  endproperty
  a_blk_rd: assert property (p_blk_rd)
    else $error("block read byte not stored");

  property p_wr_byte;
    @(posedge clk) disable iff (sys_rst)
    callOk && ep == EP_WRITE_BYTE |=> flashReq.wdata == $past(wrDataReg) && flashReqValid;
  endproperty
  a_wr_byte: assert property (p_wr_byte)
    else $error("write byte data wrong");

  property p_blk_limit;
    @(posedge clk) disable iff (sys_rst)
    callOk && ep == EP_BLOCK_WRITE && countReg > BLKW_MAX |=> stateReg == S_IDLE && cmdErrReg;
  endproperty
  a_blk_limit: assert property (p_blk_limit)
    else $error("oversize block write accepted");

  property p_exit;
    @(posedge clk) disable iff (sys_rst)
    callOk && ep == EP_EXIT |=> deviceReset ##1 !deviceReset;
  endproperty
  a_exit: assert property (p_exit)
    else $error("exit did not pulse reset");

  property p_serial_hold;
    @(posedge clk) disable iff (sys_rst)
    serialModeReg |=> serialModeReg && coreHoldReg;
  endproperty
  a_serial_hold: assert property (p_serial_hold)
    else $error("serial mode left without reset");

  property p_release;
    @(posedge clk) disable iff (sys_rst)
    $fell(coreHoldReg) |-> $past(stateReg) == S_STEP && $past(remain) == 8'h01;
  endproperty
  a_release: assert property (p_release)
    else $error("core released early");

  property p_unknown;
    @(posedge clk) disable iff (sys_rst)
    callOk && badCmd |=> !flashReqValid && !ramReqValid && stateReg == S_IDLE;
  endproperty
  a_unknown: assert property (p_unknown)
    else $error("unknown entry touched flash");

  c_blk_wr: cover property (@(posedge clk) disable iff (sys_rst)
    stateReg == S_RAMLAT ##[1:40] stateReg == S_RAMLAT);
  c_mass: cover property (@(posedge clk) disable iff (sys_rst) massDone);
  c_key_err: cover property (@(posedge clk) disable iff (sys_rst) callWr && !keyLive);
endmodule

// *** pkg/ufps_pkg.sv ***
// Constants, types and register map of the flash programming service
package ufps_pkg;
  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_ADDR_LO  = 8'ha8;
  localparam logic [7:0] IDX_ADDR_HI  = 8'ha9;
  localparam logic [7:0] IDX_RD_DATA  = 8'haa;
  localparam logic [7:0] IDX_WR_DATA  = 8'hab;
  localparam logic [7:0] IDX_CALL     = 8'hc0;
  localparam logic [7:0] IDX_ACC      = 8'hc1;
  localparam logic [7:0] IDX_XPTR     = 8'hc2;
  localparam logic [7:0] IDX_STATUS   = 8'hc3;
  localparam logic [7:0] IDX_TIMING   = 8'he1;
  localparam logic [7:0] IDX_KEY      = 8'he2;
  localparam logic [7:0] IDX_COUNT    = 8'hf1;
  // Status bit positions
  localparam int unsigned ST_BUSY_BIT  = 0;
  localparam int unsigned ST_SER_BIT   = 1;
  localparam int unsigned ST_KERR_BIT  = 2;
  localparam int unsigned ST_CERR_BIT  = 3;
  localparam int unsigned ST_KEY_BIT   = 4;
  // Entry points
  localparam logic [7:0] EP_SERIAL    = 8'h00;
  localparam logic [7:0] EP_READ_BYTE = 8'h11;
  localparam logic [7:0] EP_WRITE_BYTE = 8'h14;
  localparam logic [7:0] EP_PAGE_ERASE = 8'h17;
  localparam logic [7:0] EP_MASS_ERASE = 8'h1a;
  localparam logic [7:0] EP_BLOCK_WRITE = 8'h23;
  localparam logic [7:0] EP_BLOCK_READ = 8'h26;
  localparam logic [7:0] EP_EXIT      = 8'h62;
  // Values and limits
  localparam logic [7:0] MASS_CONFIRM = 8'h55;
  localparam logic [7:0] KEY_VALUE    = 8'h98;
  localparam logic [7:0] BLKW_MAX     = 8'h10;
  localparam logic [7:0] BYTE_RST     = 8'h00;
  localparam int unsigned KEY_WINDOW  = 6;
  localparam int unsigned APB_AW      = 12;

  // Flash macro operations
  typedef enum logic [1:0] {
    FOP_READ  = 2'h0,
    FOP_WRITE = 2'h1,
    FOP_PAGE  = 2'h2,
    FOP_MASS  = 2'h3
  } ufps_fop_t;

  // Sequencer states, Gray in the order listed
  typedef enum logic [2:0] {
    S_IDLE   = 3'h0,
    S_WAIT   = 3'h1,
    S_STEP   = 3'h3,
    S_RAMGET = 3'h2,
    S_RAMLAT = 3'h6
  } ufps_state_t;

  // Request to the flash array controller
  typedef struct packed {
    ufps_fop_t   op;
    logic [15:0] addr;
    logic [7:0]  wdata;
    logic [7:0]  timing;
  } ufps_flash_req_t;

  // Request to data RAM
  typedef struct packed {
    logic       we;
    logic [7:0] addr;
    logic [7:0] wdata;
  } ufps_ram_req_t;
endpackage

// *** logic/ufps_key_timer.sv ***
// Call key window timer
`timescale 1ns/1ps
module ufps_key_timer import ufps_pkg::*; #(
  parameter int unsigned WINDOW = KEY_WINDOW
) (
  input  wire logic clk,
  input  wire logic sys_rst,
  input  wire logic keyLoad,
  input  wire logic keyKill,
  output logic      keyLive
);
  localparam int unsigned CW = $clog2(WINDOW + 1);
  localparam logic [CW-1:0] LOAD = CW'(WINDOW);

  logic [CW-1:0] ageReg;

  // Load on a valid key, count down each cycle, expire at zero
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ageReg <= '0;
    end else if (keyLoad) begin
      ageReg <= LOAD;
    end else if (keyKill) begin
      ageReg <= '0;
    end else if (ageReg != '0) begin
      ageReg <= ageReg - CW'(1);
    end
  end

  assign keyLive = (ageReg != '0);

  property p_key_expire;
    @(posedge clk) disable iff (sys_rst)
    keyLoad ##1 (!keyLoad && !keyKill) [*5] |=> keyLive ##1 (!keyLive || $past(keyLoad));
  endproperty
  a_key_expire: assert property (p_key_expire)
    else $error("key window length wrong");
endmodule

// *** verif/ufps_far_model.sv ***
// Far-side model: flash array controller and data RAM
`timescale 1ns/1ps
module ufps_far_model import ufps_pkg::*; (
  input  wire logic       clk,
  input  wire logic       slowAck,
  input  ufps_flash_req_t flashReq,
  input  wire logic       flashReqValid,
  output logic            flashAck,
  output logic [7:0]      flashRdata,
  input  ufps_ram_req_t   ramReq,
  input  wire logic       ramReqValid,
  output logic [7:0]      ramRdata
);
  logic [7:0]      fmem [0:65535];
  logic [7:0]      ram [0:255];
  ufps_flash_req_t cur;
  int              ackCnt;
  int              opCount;
  logic [7:0]      noise;

  // Blank flash, cleared RAM, flashAck low
  initial begin
    for (int k = 0; k < 65536; k++) fmem[k] = 8'hff;
    for (int k = 0; k < 256; k++) ram[k] = 8'h00;
    flashAck = 1'b0;
    ackCnt = 0;
    opCount = 0;
    noise = 8'h00;
  end

  // Flash controller: one request at a time, ack two or six cycles later
  always @(posedge clk) begin
    flashAck <= 1'b0;
    flashRdata <= noise; // Read data is junk outside the ack
    noise <= noise + 8'h3b;
    if (flashReqValid) begin
      cur <= flashReq;
      ackCnt <= slowAck ? 5 : 1;
    end else if (ackCnt == 1) begin
      flashAck <= 1'b1;
      opCount <= opCount + 1;
      ackCnt <= 0;
      case (cur.op)
        FOP_READ: flashRdata <= fmem[cur.addr];
        FOP_WRITE: fmem[cur.addr] <= cur.wdata;
        FOP_MASS: for (int k = 0; k < 65536; k++) fmem[k] <= 8'hff;
        default: ;
      endcase
    end else if (ackCnt > 1) begin
      ackCnt <= ackCnt - 1;
    end
  end

  // Data RAM, pointer taken as already segmented; read data one cycle later
  always @(posedge clk) begin
    ramRdata <= ~noise;
    if (ramReqValid && ramReq.we) begin
      ram[ramReq.addr] <= ramReq.wdata;
    end else if (ramReqValid) begin
      ramRdata <= ram[ramReq.addr];
    end
  end
endmodule

// *** verif/user_flash_program_service_tb.sv ***
// Self-checking bench for the flash programming service sequencer
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin n_compared++; if ((gt) !== (ex)) begin err_count++; \
  $display("mismatch %s exp %h got %h", nm, ex, gt); end end
module user_flash_program_service_tb import ufps_pkg::*; ;
  logic            clk, sys_rst, psel, penable, pwrite, pready, pslverr;
  logic [11:0]     paddr;
  logic [31:0]     pwdata, prdata, q;
  ufps_flash_req_t flashReq;
  ufps_ram_req_t   ramReq;
  logic            flashReqValid, flashAck, ramReqValid, serialExit;
  logic            serialMode, coreHold, deviceReset, slowAck, e;
  logic [7:0]      flashRdata, ramRdata;
  int              err_count, n_compared, cycles, ops;

  ufps_flash_service i_dut (.clk(clk), .sys_rst(sys_rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .flashReq(flashReq),
    .flashReqValid(flashReqValid), .flashAck(flashAck), .flashRdata(flashRdata),
    .ramReq(ramReq), .ramReqValid(ramReqValid), .ramRdata(ramRdata),
    .serialExit(serialExit), .serialMode(serialMode), .coreHold(coreHold),
    .deviceReset(deviceReset));
  ufps_far_model i_far (.clk(clk), .slowAck(slowAck), .flashReq(flashReq),
    .flashReqValid(flashReqValid), .flashAck(flashAck), .flashRdata(flashRdata),
    .ramReq(ramReq), .ramReqValid(ramReqValid), .ramRdata(ramRdata));

  // Verdict and end of run
  task automatic stop_test;
    if (err_count == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // 125 MHz clock
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // Hang guard
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      err_count++;
      stop_test();
    end
  end

  // One APB transfer: setup, access until pready, then release
  task automatic apb(input logic w, input logic [7:0] idx, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1); // Only the hang guard ends a lost answer
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    apb(1'b1, idx, d);
  endtask

  task automatic rd(input logic [7:0] idx, input logic [31:0] m, input logic [31:0] x);
    apb(1'b0, idx, 32'h0);
    `CHK("register", x, q & m)
  endtask

  // Key load, a gap of idle cycles, then the call write
  task automatic call(input logic [7:0] ep, input int gap);
    wr(IDX_KEY, {24'h0, KEY_VALUE});
    repeat (gap) @(posedge clk);
    wr(IDX_CALL, {24'h0, ep});
  endtask

  // Wait until the core is released
  task automatic waitFree;
    int n;
    n = 0;
    @(posedge clk);
    while (coreHold !== 1'b0 && n < 2000) begin
      @(posedge clk);
      n++;
    end
    `CHK("coreHold", 1'b0, coreHold)
  endtask

  // Wait for deviceReset (sel 0) or serialMode (sel 1) to be high
  task automatic waitFor(input logic sel, input string nm);
    int n;
    logic s;
    n = 0;
    s = sel ? serialMode : deviceReset;
    while (s !== 1'b1 && n < 200) begin
      @(posedge clk);
      n++;
      s = sel ? serialMode : deviceReset;
    end
    `CHK(nm, 1'b1, s)
  endtask

  // Reset held three cycles
  task automatic rst;
    sys_rst <= 1'b1;
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
  endtask

  // Check an error status bit, no flash access made, then clear errors
  task automatic errChk(input int bitPos);
    rd(IDX_STATUS, 32'h1 << bitPos, 32'h1 << bitPos);
    `CHK("opCount", ops, i_far.opCount)
    wr(IDX_STATUS, 32'h0c);
  endtask

  // Main sequence
  initial begin
    {sys_rst, psel, penable, pwrite, serialExit, slowAck} = 6'h20;
    paddr = 12'h000;
    pwdata = 32'h0;
    err_count = 0;
    n_compared = 0;
    cycles = 0;
    rst();
    rd(IDX_STATUS, 32'hffffffff, 32'h0);
    rd(IDX_RD_DATA, 32'hffffffff, 32'h0);
    apb(1'b0, 8'h10, 32'h0);
    `CHK("pslverr", 1'b1, e)
    wr(IDX_TIMING, 32'h2a);
    wr(IDX_ADDR_HI, 32'h12);
    wr(IDX_ADDR_LO, 32'h34);
    wr(IDX_WR_DATA, 32'ha5);
    call(EP_WRITE_BYTE, 0);
    waitFree();
    `CHK("wreq", {FOP_WRITE, 16'h1234, 8'ha5, 8'h2a}, i_far.cur)
    `CHK("fmem", 8'ha5, i_far.fmem[16'h1234])
    slowAck <= 1'b1;
    call(EP_READ_BYTE, 3);
    waitFree();
    rd(IDX_RD_DATA, 32'hff, 32'ha5);
    ops = i_far.opCount;
    call(EP_READ_BYTE, 4);
    errChk(ST_KERR_BIT);
    call(EP_PAGE_ERASE, 0);
    waitFree();
    `CHK("preq", {FOP_PAGE, 16'h1234}, {i_far.cur.op, i_far.cur.addr})
    slowAck <= 1'b0;
    for (int k = 0; k < 16; k++) i_far.ram[8'h40 + k] = 8'hc0 + 8'(k);
    wr(IDX_XPTR, 32'h40);
    wr(IDX_ADDR_HI, 32'h20);
    wr(IDX_ADDR_LO, 32'h30);
    wr(IDX_COUNT, 32'h10);
    ops = i_far.opCount;
    call(EP_BLOCK_WRITE, 0);
    waitFree();
    `CHK("bwOps", ops + 16, i_far.opCount)
    for (int k = 0; k < 16; k++) `CHK("bw", 8'hc0 + 8'(k), i_far.fmem[16'h2030 + k])
    ops = i_far.opCount;
    wr(IDX_COUNT, 32'h11);
    call(EP_BLOCK_WRITE, 0);
    errChk(ST_CERR_BIT);
    wr(IDX_XPTR, 32'h80);
    wr(IDX_COUNT, 32'hff);
    call(EP_BLOCK_READ, 0);
    waitFree();
    for (int k = 0; k < 16; k++) `CHK("br", 8'hc0 + 8'(k), i_far.ram[8'h80 + k])
    `CHK("brOps", ops + 255, i_far.opCount)
    ops = i_far.opCount;
    wr(IDX_COUNT, 32'h0);
    call(EP_BLOCK_READ, 0);
    rd(IDX_STATUS, 32'h1, 32'h0);
    `CHK("br0", ops, i_far.opCount)
    call(8'h55, 0);
    errChk(ST_CERR_BIT);
    call(8'hff, 0);
    errChk(ST_CERR_BIT);
    wr(IDX_ACC, 32'h54);
    call(EP_MASS_ERASE, 0);
    errChk(ST_CERR_BIT);
    call(EP_EXIT, 0);
    waitFor(1'b0, "exitReset");
    rst();
    call(EP_SERIAL, 0);
    waitFor(1'b1, "serialMode");
    call(EP_READ_BYTE, 0);
    errChk(ST_SER_BIT);
    serialExit <= 1'b1;
    @(posedge clk);
    serialExit <= 1'b0;
    waitFor(1'b0, "serialReset");
    rst();
    wr(IDX_ACC, {24'h0, MASS_CONFIRM});
    call(EP_MASS_ERASE, 0);
    waitFor(1'b1, "massSerial");
    repeat (8) @(posedge clk);
    `CHK("mass", FOP_MASS, i_far.cur.op)
    `CHK("massHold", 1'b1, coreHold)
    `CHK("erased", 8'hff, i_far.fmem[16'h1234])
    rst();
    stop_test();
  end
endmodule
